// >>> core/txe_pkg.sv
// Constants, register map and code tables for the transfer error coder.
// Assumes a 16-bit register port with byte-style offsets.
package txe_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CODE_W = 6;
  localparam int ECC_W = 8;
  localparam int RP_W = 8;

  // Register offsets
  localparam logic [7:0] ERR_WORD_ADDR = 8'h04;
  localparam logic [7:0] TAPE_CTRL_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h30;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Field positions
  localparam int FAIL_LSB = 10;
  localparam int INT_LSB = 0;
  localparam int NOREPO_BIT = 15;
  localparam int FMT_MSB = 14;
  localparam int FMT_LSB = 12;
  localparam int CTRL_KEEP_LSB = 8;
  localparam logic [2:0] FMT_MAX_VALID = 3'h1;

  // Interrupt codes
  localparam logic [5:0] INT_DONE = 6'h01;
  localparam logic [5:0] INT_DATA_CHECK = 6'h12;
  localparam logic [5:0] INT_READ_OPP = 6'h13;
  localparam logic [5:0] INT_UNREAD = 6'h14;
  localparam logic [5:0] INT_RETRY = 6'h15;
  localparam logic [5:0] INT_EOT_ERR = 6'h16;
  localparam logic [5:0] INT_BAD_TAPE = 6'h17;
  localparam logic [5:0] INT_FMT_FAULT = 6'h18;
  localparam logic [5:0] INT_XPT_FAULT = 6'h19;

  // Data-check failure codes
  localparam logic [5:0] FAIL_NONE = 6'h00;
  localparam logic [5:0] FAIL_ECC_PE = 6'h04;
  localparam logic [5:0] FAIL_ECC_ANY = 6'h05;
  localparam logic [5:0] FAIL_WF_PE = 6'h06;
  localparam logic [5:0] FAIL_WF_GCR = 6'h07;
  localparam logic [5:0] FAIL_READ_STATUS_WORD = 6'h08;
  localparam logic [5:0] FAIL_CRC = 6'h09;
  localparam logic [5:0] FAIL_BUS_PAR = 6'h0a;
  localparam logic [5:0] FAIL_REC_LEN = 6'h0b;

  // Amplitude, pointer, incorrectable, two-track, single-track
  localparam logic [7:0] ECC_PE_WRITE_MASK = 8'h1f;

  // Formatter fault sources, lowest index wins
  localparam int FMT_N = 19;
  localparam int FMT_IW = 5;
  localparam int LOOP_BASE = 4;
  localparam int LOOP_PHASES = 9;
  localparam logic [5:0] FMT_CODES [FMT_N] = '{
    6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h08, 6'h09, 6'h0a, 6'h0b,
    6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h06, 6'h07, 6'h10, 6'h11, 6'h12,
    6'h13};

  // Transport fault sources, lowest index wins
  localparam int XPT_N = 26;
  localparam int XPT_IW = 5;
  localparam logic [5:0] XPT_CODES [XPT_N] = '{
    6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09,
    6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h11, 6'h12, 6'h13,
    6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b};

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_PICK} txe_state_t;
endpackage

// >>> core/txe_prio_pick.sv
// Registered lowest-index-first picker over a flag vector.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module txe_prio_pick #(
  parameter int W = 8,
  parameter int IW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Sample request and flags
  input wire logic en,
  input wire logic [W-1:0] flags,
  // Registered result
  output logic any_q,
  output logic [IW-1:0] idx_q
);
  logic [IW-1:0] idx_d;

  // Lowest set flag gives the index
  always_comb begin
    idx_d = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (flags[i]) begin
        idx_d = IW'(i);
      end
    end
  end

  // Capture on request
  always_ff @(posedge clk) begin
    if (srst) begin
      any_q <= 1'b0;
      idx_q <= '0;
    end else if (en) begin
      any_q <= |flags;
      idx_q <= idx_d;
    end
  end
endmodule

// >>> core/txe_xfer_err_coder.sv
// Data transfer error coder: builds the end-of-operation error word.
// Assumes all inputs synchronous to clk and one-cycle start/end pulses.
`timescale 1ns/1ps
module txe_xfer_err_coder (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [txe_pkg::ADDR_W-1:0] regAddr,
  input wire logic [txe_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [txe_pkg::DATA_W-1:0] regRdData_q,
  // Transfer framing
  input wire logic xferStart,
  input wire logic xferEnd,
  input wire logic runSignal,
  input wire logic phaseEncodedFormat,
  input wire logic writeOp,
  // Data path status
  input wire logic [txe_pkg::ECC_W-1:0] eccStatusWord,
  input wire logic [txe_pkg::RP_W-1:0] readPathFailFlags,
  input wire logic [txe_pkg::RP_W-1:0] readPathFlagWord,
  input wire logic readStatusBad,
  input wire logic crcMismatch,
  input wire logic hostBusParityErr,
  input wire logic retryLenMismatch,
  // Retry outcome
  input wire logic retryNeeded,
  input wire logic retryReverse,
  input wire logic recordUnrecoverable,
  input wire logic pastEndWriteError,
  input wire logic positionLost,
  input wire logic writeRetriesFailed,
  // Formatter faults
  input wire logic invalidCmd,
  input wire logic xferWhileNonXfer,
  input wire logic wseqEncodeErr,
  input wire logic cmdLoopMismatch,
  input wire logic [3:0] cmdLoopPhase,
  input wire logic eccRomParity,
  input wire logic tseqRomParity,
  input wire logic wseqLeftMissing,
  input wire logic xferLatchParity,
  input wire logic tseqDoneMissing,
  input wire logic wseqParity,
  // Transport faults, one flag per code
  input wire logic [txe_pkg::XPT_N-1:0] transportFault,
  // Report
  output logic [txe_pkg::DATA_W-1:0] errorWord_q,
  output logic reportValid_q,
  output logic holdAtRecordStart_q,
  output logic busy_q
);
  txe_pkg::txe_state_t state_q;
  logic [txe_pkg::DATA_W-1:0] ctrl_q;
  logic runSeen_q;
  logic [txe_pkg::FMT_N-1:0] fmtVec;
  logic fmtAny;
  logic [txe_pkg::FMT_IW-1:0] fmtIdx;
  logic xptAny;
  logic [txe_pkg::XPT_IW-1:0] xptIdx;
  logic [5:0] dcFail_d;
  logic [5:0] dcFail_q;
  logic [5:0] dataInt_d;
  logic [5:0] dataInt_q;
  logic [txe_pkg::DATA_W-1:0] word_d;
  logic [txe_pkg::DATA_W-1:0] rd_d;
  logic endTake;
  logic noRepo;
  logic [2:0] fmtSel;

  // Counts set bits in a flag word
  function automatic logic [4:0] countOnes(
    input logic [2*txe_pkg::RP_W-1:0] v
  );
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 2 * txe_pkg::RP_W; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  // Packs failure and interrupt fields into one word
  function automatic logic [txe_pkg::DATA_W-1:0] packWord(
    input logic [5:0] fail,
    input logic [5:0] intr
  );
    logic [txe_pkg::DATA_W-1:0] w;
    w = txe_pkg::WORD_RESET;
    w[txe_pkg::FAIL_LSB +: txe_pkg::CODE_W] = fail;
    w[txe_pkg::INT_LSB +: txe_pkg::CODE_W] = intr;
    return w;
  endfunction

  assign endTake = xferEnd && (state_q != txe_pkg::ST_PICK);
  assign noRepo = ctrl_q[txe_pkg::NOREPO_BIT];
  assign fmtSel = ctrl_q[txe_pkg::FMT_MSB:txe_pkg::FMT_LSB];

  // Operation sequencing
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= txe_pkg::ST_IDLE;
    end else begin
      case (state_q)
        txe_pkg::ST_IDLE, txe_pkg::ST_XFER: begin
          if (xferEnd) begin
            state_q <= txe_pkg::ST_PICK;
          end else if (xferStart) begin
            state_q <= txe_pkg::ST_XFER;
          end
        end
        default: begin
          state_q <= txe_pkg::ST_IDLE; // Report cycle lasts one clock
        end
      endcase
    end
  end

  // Busy flag follows the operation
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q == txe_pkg::ST_XFER && !xferEnd)
        || (state_q == txe_pkg::ST_IDLE && xferStart && !xferEnd);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      runSeen_q <= 1'b0;
    end else if (xferStart && state_q != txe_pkg::ST_XFER) begin
      runSeen_q <= runSignal;
    end else if (runSignal) begin
      runSeen_q <= 1'b1;
    end
  end

  always_comb begin
    fmtVec = '0;
    fmtVec[0] = invalidCmd;
    fmtVec[1] = xferWhileNonXfer;
    fmtVec[2] = wseqEncodeErr
      || (writeOp && fmtSel > txe_pkg::FMT_MAX_VALID);
    fmtVec[3] = !(runSeen_q || runSignal);
    fmtVec[13] = eccRomParity;
    fmtVec[14] = tseqRomParity;
    fmtVec[15] = wseqLeftMissing;
    fmtVec[16] = xferLatchParity;
    fmtVec[17] = tseqDoneMissing;
    fmtVec[18] = wseqParity;
  end

  logic [txe_pkg::LOOP_PHASES-1:0] loopHit;
  for (genvar p = 0; p < txe_pkg::LOOP_PHASES; p++) begin : g_loop
    assign loopHit[p] = cmdLoopMismatch && (cmdLoopPhase == 4'(p));
  end

  logic [txe_pkg::FMT_N-1:0] fmtAll;
  assign fmtAll = fmtVec | (txe_pkg::FMT_N'(loopHit) << txe_pkg::LOOP_BASE);

  txe_prio_pick #(
    .W(txe_pkg::FMT_N),
    .IW(txe_pkg::FMT_IW)
  ) u_fmt_pick (
    .clk(clk),
    .srst(srst),
    .en(endTake),
    .flags(fmtAll),
    .any_q(fmtAny),
    .idx_q(fmtIdx)
  );

  txe_prio_pick #(
    .W(txe_pkg::XPT_N),
    .IW(txe_pkg::XPT_IW)
  ) u_xpt_pick (
    .clk(clk),
    .srst(srst),
    .en(endTake),
    .flags(transportFault),
    .any_q(xptAny),
    .idx_q(xptIdx)
  );

  // Data-check failure code, last match wins
  always_comb begin
    dcFail_d = txe_pkg::FAIL_NONE;
    if (retryLenMismatch) begin
      dcFail_d = txe_pkg::FAIL_REC_LEN;
    end
    if (hostBusParityErr) begin
      dcFail_d = txe_pkg::FAIL_BUS_PAR;
    end
    if (phaseEncodedFormat && writeOp && crcMismatch) begin
      dcFail_d = txe_pkg::FAIL_CRC;
    end
    if (readStatusBad) begin
      dcFail_d = txe_pkg::FAIL_READ_STATUS_WORD;
    end
    if (!phaseEncodedFormat && writeOp
        && countOnes({readPathFailFlags, readPathFlagWord}) > 5'h01) begin
      dcFail_d = txe_pkg::FAIL_WF_GCR;
    end
    if (phaseEncodedFormat && writeOp
        && |{readPathFailFlags, readPathFlagWord}) begin
      dcFail_d = txe_pkg::FAIL_WF_PE;
    end
    if (|eccStatusWord) begin
      dcFail_d = txe_pkg::FAIL_ECC_ANY;
    end
    if (phaseEncodedFormat && writeOp
        && |(eccStatusWord & txe_pkg::ECC_PE_WRITE_MASK)) begin
      dcFail_d = txe_pkg::FAIL_ECC_PE;
    end
  end

  // Interrupt class for data and retry outcomes
  always_comb begin
    dataInt_d = txe_pkg::INT_DONE;
    if (positionLost || writeRetriesFailed) begin
      dataInt_d = txe_pkg::INT_BAD_TAPE;
    end else if (noRepo && pastEndWriteError) begin
      dataInt_d = txe_pkg::INT_EOT_ERR;
    end else if (noRepo && retryNeeded) begin
      dataInt_d = txe_pkg::INT_RETRY;
    end else if (recordUnrecoverable) begin
      dataInt_d = txe_pkg::INT_UNREAD;
    end else if (retryReverse) begin
      dataInt_d = txe_pkg::INT_READ_OPP;
    end else if (dcFail_d != txe_pkg::FAIL_NONE || retryNeeded
                 || pastEndWriteError) begin
      dataInt_d = txe_pkg::INT_DATA_CHECK;
    end
  end

  // Capture data-check result with the pickers
  always_ff @(posedge clk) begin
    if (srst) begin
      dcFail_q <= txe_pkg::FAIL_NONE;
      dataInt_q <= txe_pkg::INT_DONE;
    end else if (endTake) begin
      dcFail_q <= dcFail_d;
      dataInt_q <= dataInt_d;
    end
  end

  // Final word: formatter, then transport, then data
  always_comb begin
    if (fmtAny) begin
      word_d = packWord(txe_pkg::FMT_CODES[fmtIdx],
        txe_pkg::INT_FMT_FAULT);
    end else if (xptAny) begin
      word_d = packWord(txe_pkg::XPT_CODES[xptIdx],
        txe_pkg::INT_XPT_FAULT);
    end else begin
      // same failure set as data check
      word_d = packWord(dcFail_q, dataInt_q);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      errorWord_q <= txe_pkg::WORD_RESET;
      reportValid_q <= 1'b0;
    end else begin
      reportValid_q <= (state_q == txe_pkg::ST_PICK);
      if (state_q == txe_pkg::ST_PICK) begin
        errorWord_q <= word_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      holdAtRecordStart_q <= 1'b0;
    end else if (state_q == txe_pkg::ST_PICK) begin
      holdAtRecordStart_q <= !fmtAny && !xptAny
        && (dataInt_q == txe_pkg::INT_RETRY
            || dataInt_q == txe_pkg::INT_EOT_ERR);
    end else if (xferStart) begin
      holdAtRecordStart_q <= 1'b0;
    end
  end

  // Tape control register, upper byte writable
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= txe_pkg::CTRL_RESET;
    end else if (regWrStb && regAddr == txe_pkg::TAPE_CTRL_ADDR) begin
      ctrl_q <= {regWrData[txe_pkg::DATA_W-1:txe_pkg::CTRL_KEEP_LSB],
        txe_pkg::CTRL_RESET[txe_pkg::CTRL_KEEP_LSB-1:0]};
    end
  end

  // Read mux
  always_comb begin
    case (regAddr)
      txe_pkg::ERR_WORD_ADDR: rd_d = errorWord_q;
      txe_pkg::TAPE_CTRL_ADDR: rd_d = ctrl_q;
      txe_pkg::STATUS_ADDR: rd_d = {13'h0000, holdAtRecordStart_q,
        runSeen_q, busy_q};
      default: rd_d = 16'h0000;
    endcase
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdData_q <= 16'h0000;
    end else begin
      regRdData_q <= regRdStb ? rd_d : 16'h0000;
    end
  end
endmodule

// >>> verif/txe_host_model.sv
// Stand-in for the host adapter and transports: run pulse, fault flags.
// Assumes the coder's clock and bench-driven control inputs.
`timescale 1ns/1ps
module txe_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Controls from the bench
  input wire logic xferStart,
  input wire logic runEn,
  input wire logic faultOn,
  input wire logic [4:0] faultIdx,
  // Toward the coder
  output logic runSignal,
  output logic [txe_pkg::XPT_N-1:0] transportFault
);
  always_ff @(posedge clk) begin
    if (srst) begin
      runSignal <= 1'b0;
    end else begin
      runSignal <= xferStart & runEn; // One-cycle pulse, low otherwise
    end
  end
  // One transport fault flag at a time, chosen by index
  assign transportFault = faultOn ?
    {{(txe_pkg::XPT_N-1){1'b0}}, 1'b1} << faultIdx : '0;
endmodule

// >>> verif/txe_xfer_monitor.sv
// Checker for the transfer error coder report and register port.
// Assumes it is bound to the coder top and sees only its ports.
`timescale 1ns/1ps
module txe_xfer_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Inputs watched
  input wire logic regRdStb,
  input wire logic xferStart,
  input wire logic xferEnd,
  input wire logic invalidCmd,
  input wire logic [txe_pkg::ECC_W-1:0] eccStatusWord,
  input wire logic [txe_pkg::XPT_N-1:0] transportFault,
  // Outputs watched
  input wire logic [txe_pkg::DATA_W-1:0] regRdData_q,
  input wire logic [txe_pkg::DATA_W-1:0] errorWord_q,
  input wire logic reportValid_q,
  input wire logic holdAtRecordStart_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_valid_two: assert property (
    xferEnd && !$past(xferEnd) |-> ##2 reportValid_q)
    else $error("report not two cycles after end");
  chk_valid_cause: assert property (
    reportValid_q |-> $past(xferEnd, 2))
    else $error("report without end of operation");
  chk_valid_pulse: assert property (
    reportValid_q |=> !reportValid_q)
    else $error("report flag longer than one cycle");
  chk_word_stable: assert property (
    !reportValid_q |-> $stable(errorWord_q))
    else $error("error word moved without report");
  chk_gap_bits: assert property (errorWord_q[9:6] == 4'h0)
    else $error("unused error word bits set");
  chk_fmt_first: assert property (
    reportValid_q && $past(invalidCmd, 2) |-> errorWord_q == 16'h0418)
    else $error("invalid command not reported first");
  chk_ecc_any: assert property (
    reportValid_q && $past(eccStatusWord, 2) != 0
    |-> errorWord_q[15:10] != 0 && errorWord_q[5:0] != 6'h01)
    else $error("ecc flags gave no failure code");
  chk_xpt_class: assert property (
    reportValid_q && $past(transportFault, 2) != 0
    |-> errorWord_q[5:0] inside {6'h18, 6'h19})
    else $error("transport fault not reported");
  chk_hold_set: assert property (
    reportValid_q && errorWord_q[5:0] inside {6'h15, 6'h16}
    |-> ##[0:1] holdAtRecordStart_q)
    else $error("hold at record start not set");
  chk_hold_clear: assert property (
    xferStart |=> !holdAtRecordStart_q)
    else $error("hold not cleared by start");
  chk_rd_idle: assert property (!$past(regRdStb) |-> regRdData_q == 16'h0000)
    else $error("read data outside read cycle");

  // Main scenarios
  cov_retry: cover property (reportValid_q && errorWord_q[5:0] == 6'h15);
  cov_fmt: cover property (reportValid_q && errorWord_q[5:0] == 6'h18);
  cov_xpt: cover property (reportValid_q && errorWord_q[5:0] == 6'h19);
endmodule

bind txe_xfer_err_coder txe_xfer_monitor mon_u (.clk, .srst, .regRdStb,
  .xferStart, .xferEnd, .invalidCmd, .eccStatusWord, .transportFault,
  .regRdData_q, .errorWord_q, .reportValid_q, .holdAtRecordStart_q);

// >>> verif/testbench.sv
// Self-checking bench for the transfer error coder.
// Assumes the host model file and the bound checker are compiled too.
`timescale 1ns/1ps
module testbench;
  logic clk, srst, wrStb, rdStb, xferStart, xferEnd, runEn, runSignal;
  logic pe, wop, loopMis, faultOn, hold, valid, busy;
  logic [7:0] addr, ecc, rpf, rpw;
  logic [15:0] wdata, rdata, word;
  logic [8:0] fb;
  logic [9:0] db;
  logic [3:0] loopPh;
  logic [4:0] faultIdx;
  logic [txe_pkg::XPT_N-1:0] tf;
  int errors, num_checks;
  localparam logic [5:0] FC [9] = '{6'h01, 6'h02, 6'h03, 6'h06, 6'h07,
    6'h10, 6'h11, 6'h12, 6'h13};

  txe_xfer_err_coder dut_u (.clk(clk), .srst(srst), .regAddr(addr),
    .regWrData(wdata), .regWrStb(wrStb), .regRdStb(rdStb),
    .regRdData_q(rdata), .xferStart(xferStart), .xferEnd(xferEnd),
    .runSignal(runSignal), .phaseEncodedFormat(pe), .writeOp(wop),
    .eccStatusWord(ecc), .readPathFailFlags(rpf), .readPathFlagWord(rpw),
    .readStatusBad(db[0]), .crcMismatch(db[1]), .hostBusParityErr(db[2]),
    .retryLenMismatch(db[3]), .retryNeeded(db[4]), .retryReverse(db[5]),
    .recordUnrecoverable(db[6]), .pastEndWriteError(db[7]),
    .positionLost(db[8]), .writeRetriesFailed(db[9]),
    .invalidCmd(fb[0]), .xferWhileNonXfer(fb[1]), .wseqEncodeErr(fb[2]),
    .cmdLoopMismatch(loopMis), .cmdLoopPhase(loopPh),
    .eccRomParity(fb[3]), .tseqRomParity(fb[4]), .wseqLeftMissing(fb[5]),
    .xferLatchParity(fb[6]), .tseqDoneMissing(fb[7]), .wseqParity(fb[8]),
    .transportFault(tf), .errorWord_q(word), .reportValid_q(valid),
    .holdAtRecordStart_q(hold), .busy_q(busy));

  txe_host_model host_u (.clk(clk), .srst(srst), .xferStart(xferStart),
    .runEn(runEn), .faultOn(faultOn), .faultIdx(faultIdx),
    .runSignal(runSignal), .transportFault(tf));

  // Clock at 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Verdict and end of run
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compare and count
  task check(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Register write, one strobe cycle
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clk) wrStb <= 1'b0;
  endtask

  // Register read, data checked in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk) rdStb <= 1'b0;
    #1 check(rdata, e);
  endtask

  // One operation: set status, start, end, wait for report, compare
  task op(input logic [8:0] f, input logic [9:0] d, input logic [7:0] e,
    input logic [15:0] rp, input logic [1:0] m, input logic [5:0] x,
    input logic [5:0] ti, input logic [15:0] exp);
    int k;
    @(posedge clk);
    fb <= f;
    db <= d;
    ecc <= e;
    {rpf, rpw} <= rp;
    {pe, wop} <= m;
    runEn <= !x[5];
    loopMis <= x[4];
    loopPh <= x[3:0];
    {faultOn, faultIdx} <= ti;
    xferStart <= 1'b1;
    @(posedge clk) xferStart <= 1'b0;
    #1 check({15'h0, busy}, 16'h0001);
    repeat (2) @(posedge clk);
    xferEnd <= 1'b1;
    @(posedge clk) xferEnd <= 1'b0;
    for (k = 0; k < 4 && valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (valid !== 1'b1) begin
      errors++;
      $display("[FAIL] t=%0t no report got=%h exp=%h", $time, word, exp);
      close_out();
    end
    check(word, exp);
    check({15'h0, busy}, 16'h0000);
  endtask

  // Error word from failure and interrupt codes
  function automatic logic [15:0] w(input logic [5:0] f, input logic [5:0] i);
    return {f, 4'h0, i};
  endfunction

  // Main sequence
  initial begin
    int i;
    errors = 0;
    num_checks = 0;
    srst = 1'b1;
    {wrStb, rdStb, xferStart, xferEnd, pe, wop, loopMis, faultOn} = '0;
    runEn = 1'b1;
    {addr, ecc, rpf, rpw, wdata, fb, db, loopPh, faultIdx} = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(txe_pkg::TAPE_CTRL_ADDR, 16'h0000);
    rd(txe_pkg::STATUS_ADDR, 16'h0000);
    wr(txe_pkg::ERR_WORD_ADDR, 16'hffff);
    rd(txe_pkg::ERR_WORD_ADDR, 16'h0000);
    rd(8'h3c, 16'h0000);
    wr(txe_pkg::TAPE_CTRL_ADDR, 16'hffff);
    rd(txe_pkg::TAPE_CTRL_ADDR, 16'hff00);
    wr(txe_pkg::TAPE_CTRL_ADDR, 16'h0000);
    $display("registers done");
    op(0, 0, 0, 0, 0, 0, 0, 16'h0001);
    op(0, 0, 8'h01, 0, 2'b11, 0, 0, w(6'h04, 6'h12));
    op(0, 0, 8'h20, 0, 2'b11, 0, 0, w(6'h05, 6'h12));
    op(0, 0, 8'h80, 0, 2'b00, 0, 0, w(6'h05, 6'h12));
    op(0, 0, 0, 16'h0100, 2'b11, 0, 0, w(6'h06, 6'h12));
    op(0, 0, 0, 16'h0101, 2'b01, 0, 0, w(6'h07, 6'h12));
    op(0, 0, 0, 16'h0001, 2'b01, 0, 0, 16'h0001);
    op(0, 10'h001, 0, 0, 0, 0, 0, w(6'h08, 6'h12));
    op(0, 10'h002, 0, 0, 2'b11, 0, 0, w(6'h09, 6'h12));
    op(0, 10'h004, 0, 0, 0, 0, 0, w(6'h0a, 6'h12));
    op(0, 10'h008, 0, 0, 0, 0, 0, w(6'h0b, 6'h12));
    op(0, 10'h024, 0, 0, 0, 0, 0, w(6'h0a, txe_pkg::INT_READ_OPP));
    op(0, 10'h044, 0, 0, 0, 0, 0, w(6'h0a, txe_pkg::INT_UNREAD));
    rd(txe_pkg::ERR_WORD_ADDR, w(6'h0a, txe_pkg::INT_UNREAD));
    $display("data check done");
    wr(txe_pkg::TAPE_CTRL_ADDR, 16'h8000);
    op(0, 10'h014, 0, 0, 0, 0, 0, w(6'h0a, 6'h15));
    check({15'h0, hold}, 16'h0001);
    rd(txe_pkg::STATUS_ADDR, 16'h0006);
    op(0, 10'h084, 0, 0, 2'b01, 0, 0, w(6'h0a, 6'h16));
    op(0, 10'h184, 0, 0, 2'b01, 0, 0, w(6'h0a, 6'h17));
    check({15'h0, hold}, 16'h0000);
    wr(txe_pkg::TAPE_CTRL_ADDR, 16'h2000);
    op(0, 0, 0, 0, 2'b01, 0, 0, w(6'h03, 6'h18));
    wr(txe_pkg::TAPE_CTRL_ADDR, 16'h0000);
    $display("retry done");
    for (i = 0; i < 9; i++) begin
      op(9'h001 << i, 0, 0, 0, 0, 0, 0,
        w(FC[i], 6'h18));
    end
    op(0, 0, 0, 0, 0, 6'h20, 0, w(6'h04, 6'h18));
    rd(txe_pkg::STATUS_ADDR, 16'h0000);
    for (i = 0; i < 9; i++) begin
      op(0, 0, 0, 0, 0, {2'b01, 4'(i)}, 0,
        w(i == 0 ? 6'h05 : 6'(7 + i), 6'h18));
    end
    $display("formatter done");
    for (i = 0; i < txe_pkg::XPT_N; i++) begin
      op(0, 0, 0, 0, 0, 0, {1'b1, 5'(i)},
        w(i < 15 ? 6'(i + 1) : 6'(i + 2), 6'h19));
    end
    op(9'h001, 10'h004, 8'h01, 0, 0, 0, 6'h20, w(6'h01, 6'h18));
    $display("transport done");
    close_out();
  end
endmodule
